// [src/pav_regs.sv]
`timescale 1ns/1ps
// Function
// (RQ1) advertise 10BASE-T half bit, reset one
// (RQ2) selector field fixed read-only at 0x01
// (RQ3) selector encodings; others reserved
// (RQ4) partner ability read-only, loaded from negotiation
// (RQ5) expansion read-only, loaded after negotiation
// (RQ6) vendor reset 0x0140, reserved bits fixed
// (RQ7) bit 14 selects interrupt polarity
// (RQ8) bit 5 disables automatic polarity correction
// (RQ9) bit 4 status, writable when auto off
// (RQ10) bit 1 bypasses coding, forced 100 only
// (RQ11) bit 0 gates rx clock, not loopback
module pav_regs (
    input  wire logic              clock,              // 250 MHz system clock
    input  wire logic              rst,                // async reset, high
    input  wire pav_pkg::pav_req_t req,                // management access
    output      logic [15:0]       rdata,              // read data
    output      logic              rvalid,             // read data valid pulse
    input  wire pav_pkg::pav_an_t  an,                 // negotiation results
    input  wire logic              rx_reversed,        // async reversed wiring
    input  wire logic              loopback_ctrl,      // loopback set
    input  wire logic              an_enabled,         // negotiation enabled
    input  wire logic              forced_100tx,       // 100BASE-TX forced
    output      pav_pkg::pav_ctl_t ctl,                // steering outputs
    output      logic              restart_autoneg_bit // restart pulse
);
    import pav_pkg::*;

    logic        rev_s;
    logic        adv_10h_q;
    logic [15:0] partner_q;
    logic [15:0] expan_q;
    logic [15:0] vendor_q;
    logic [15:0] vendor_d;
    logic [15:0] vendor_rd;
    logic [15:0] adv_rd;
    logic [15:0] rdata_d;
    logic        wr_vendor;
    logic        wr_adv;
    logic [4:0]  selector;
    logic        irq_pol_q;
    logic        auto_polarity_disable_dis_q;
    logic        rx_invert_q;
    logic        rx_invert_d;
    logic        bypass_q;
    logic        bypass_d;
    logic        gating_q;
    logic        gating_d;
    logic        adv_out_q;

    // reversed wiring is seen on the line side, so it is resynced first
    pav_sync pav_sync_inst (
        .clock (clock),
        .rst   (rst),
        .d     (rx_reversed),
        .q     (rev_s)
    );

    assign selector  = PAV_SEL_8023; // RQ2 RQ3
    assign wr_vendor = req.wr && (req.addr == PAV_ADDR_VENDOR);
    assign wr_adv    = req.wr && (req.addr == PAV_ADDR_ADV);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            adv_10h_q <= 1'b1; // RQ1
        end else if (wr_adv) begin
            adv_10h_q <= req.wdata[PAV_ADV_10H_BIT]; // RQ1
        end
    end

    // any write to the advertisement asks for a fresh negotiation
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            restart_autoneg_bit <= 1'b0;
        end else begin
            restart_autoneg_bit <= wr_adv; // RQ1
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            partner_q <= PAV_PARTNER_RST; // RQ4
        end else if (an.load) begin
            partner_q <= an.partner; // RQ4
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            expan_q <= PAV_EXPAN_RST; // RQ5
        end else if (an.load) begin
            expan_q <= an.expansion; // RQ5
        end
    end

    // writable bits follow the bus; reserved bits hold their reset value
    for (genvar i = 0; i < $bits(vendor_q); i++) begin : g_vendor_bit
        if (PAV_VENDOR_WMASK[i]) begin : g_rw
            assign vendor_d[i] = wr_vendor ? req.wdata[i] : vendor_q[i];
        end else begin : g_ro
            assign vendor_d[i] = PAV_VENDOR_RST[i]; // RQ6
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            vendor_q <= PAV_VENDOR_RST; // RQ6
        end else begin
            vendor_q <= vendor_d;
        end
    end

    // polarity bit shows live status while correction is automatic
    always_comb begin
        vendor_rd = vendor_q;
        if (!vendor_q[PAV_V_APOLDIS]) begin
            vendor_rd[PAV_V_RXPOL] = rev_s; // RQ9
        end
    end

    always_comb begin
        adv_rd                      = '0;
        adv_rd[PAV_ADV_10H_BIT]     = adv_10h_q; // RQ1
        adv_rd[$bits(selector)-1:0] = selector;  // RQ2
    end

    always_comb begin
        case (req.addr)
            PAV_ADDR_ADV: begin
                rdata_d = adv_rd;
            end
            PAV_ADDR_PARTNER: begin
                rdata_d = partner_q; // RQ4
            end
            PAV_ADDR_EXPAN: begin
                rdata_d = expan_q; // RQ5
            end
            PAV_ADDR_VENDOR: begin
                rdata_d = vendor_rd; // RQ6
            end
            default: begin
                rdata_d = '0;
            end
        endcase
    end

    // read data holds until the next read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else if (req.rd) begin
            rdata <= rdata_d;
        end
    end

    // valid marks the cycle after a read request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
        end
    end

    // steering bits are registered from the control fields, bypass and gating gated by the mode inputs, rx_invert taking rev_s while correction is automatic
    assign rx_invert_d = vendor_q[PAV_V_APOLDIS]
                       ? vendor_q[PAV_V_RXPOL] : rev_s; // RQ8 RQ9
    assign bypass_d    = vendor_q[PAV_V_BYPASS]
                       && !an_enabled && forced_100tx; // RQ10
    // gating drops in loopback and never runs alongside the bypass
    assign gating_d    = vendor_q[PAV_V_RXCG] && !loopback_ctrl
                       && !vendor_q[PAV_V_BYPASS]; // RQ11

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            adv_out_q <= 1'b0;
        end else begin
            adv_out_q <= adv_10h_q; // RQ1
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_pol_q <= 1'b0;
        end else begin
            irq_pol_q <= vendor_q[PAV_V_IRQPOL]; // RQ7
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            auto_polarity_disable_dis_q <= 1'b0;
        end else begin
            auto_polarity_disable_dis_q <= vendor_q[PAV_V_APOLDIS]; // RQ8
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_invert_q <= 1'b0;
        end else begin
            rx_invert_q <= rx_invert_d; // RQ8 RQ9
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bypass_q <= 1'b0;
        end else begin
            bypass_q <= bypass_d; // RQ10
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gating_q <= 1'b0;
        end else begin
            gating_q <= gating_d; // RQ11
        end
    end

    always_comb begin
        ctl.irq_polarity          = irq_pol_q;
        ctl.auto_polarity_disable = auto_polarity_disable_dis_q;
        ctl.rx_invert             = rx_invert_q;
        ctl.coding_bypass         = bypass_q;
        ctl.rx_clock_gating       = gating_q;
        ctl.adv_10half_ability    = adv_out_q;
    end
endmodule // pav_regs

// [src/pav_pkg.sv]
package pav_pkg;
    localparam logic [4:0]  PAV_ADDR_ADV     = 5'h04;
    localparam logic [4:0]  PAV_ADDR_PARTNER = 5'h05;
    localparam logic [4:0]  PAV_ADDR_EXPAN   = 5'h06;
    localparam logic [4:0]  PAV_ADDR_VENDOR  = 5'h10;
    localparam logic [15:0] PAV_PARTNER_RST  = 16'h0000;
    localparam logic [15:0] PAV_EXPAN_RST    = 16'h0000;
    localparam logic [15:0] PAV_VENDOR_RST   = 16'h0140;
    // selector encodings
    localparam logic [4:0]  PAV_SEL_8023     = 5'h01;
    localparam logic [4:0]  PAV_SEL_8029     = 5'h02;
    localparam logic [4:0]  PAV_SEL_8025     = 5'h03;
    localparam logic [4:0]  PAV_SEL_1394     = 5'h04;
    localparam int          PAV_ADV_10H_BIT  = 5;
    localparam int          PAV_V_RPTR       = 15;
    localparam int          PAV_V_IRQPOL     = 14;
    localparam int          PAV_V_TXHIM      = 12;
    localparam int          PAV_V_SQEI       = 11;
    localparam int          PAV_V_NL10       = 10;
    localparam int          PAV_V_APOLDIS    = 5;
    localparam int          PAV_V_RXPOL      = 4;
    localparam int          PAV_V_BYPASS     = 1;
    localparam int          PAV_V_RXCG       = 0;
    // writable vendor bits; the rest are fixed reserved values
    localparam logic [15:0] PAV_VENDOR_WMASK = 16'hDC33;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } pav_req_t;

    typedef struct packed {
        logic [15:0] partner;
        logic [15:0] expansion;
        logic        load;
    } pav_an_t;

    typedef struct packed {
        logic irq_polarity;
        logic auto_polarity_disable;
        logic rx_invert;
        logic coding_bypass;
        logic rx_clock_gating;
        logic adv_10half_ability;
    } pav_ctl_t;
endpackage

// [src/pav_sync.sv]
`timescale 1ns/1ps
module pav_sync (
    input  wire logic clock, // system clock
    input  wire logic rst,   // async reset
    input  wire logic d,     // async level
    output logic      q      // synchronised level
);
    logic meta_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // pav_sync

// [dv/pav_regs_asserts.sv]
`timescale 1ns/1ps
module pav_regs_asserts (
    input wire logic              clock, // clk
    input wire logic              rst, // reset
    input wire pav_pkg::pav_req_t req, // access
    input wire logic [15:0]       rdata, // data
    input wire logic              rvalid, // valid
    input wire pav_pkg::pav_an_t  an, // results
    input wire logic              rx_reversed, // wiring
    input wire logic              loopback_ctrl, // loop
    input wire logic              an_enabled, // an on
    input wire logic              forced_100tx, // forced
    input wire pav_pkg::pav_ctl_t ctl, // steering
    input wire logic              restart_autoneg_bit // pulse
);
    import pav_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic wv;
    assign wv = req.wr && req.addr == PAV_ADDR_VENDOR;
    sel_fixed_a: assert property (req.rd && req.addr == PAV_ADDR_ADV
        |=> rdata[4:0] == PAV_SEL_8023) else $error("sel");
    lp_load_a: assert property (an.load ##1 req.rd && !an.load &&
        req.addr == PAV_ADDR_PARTNER |=> rdata == $past(an.partner, 2))
        else $error("lp");
    vnd_rsvd_a: assert property (req.rd && req.addr == PAV_ADDR_VENDOR
        |=> (rdata & ~PAV_VENDOR_WMASK)
        == (PAV_VENDOR_RST & ~PAV_VENDOR_WMASK)) else $error("rsvd");
    irq_pol_a: assert property (wv ##1 !req.wr |=>
        ctl.irq_polarity == $past(req.wdata[14], 2)) else $error("irq");
    rx_force_a: assert property (wv && req.wdata[5] ##1 !req.wr |=>
        ctl.rx_invert == $past(req.wdata[4], 2)) else $error("inv");
    coding_bypass_a: assert property (ctl.coding_bypass |->
        !$past(an_enabled) && $past(forced_100tx)) else $error("byp");
    rx_gate_a: assert property (ctl.rx_clock_gating |->
        !$past(loopback_ctrl)) else $error("gate");
    gate_excl_a: assert property (ctl.rx_clock_gating |->
        !ctl.coding_bypass) else $error("gate with bypass");
    adv_restart_a: assert property (req.wr && req.addr == PAV_ADDR_ADV
        |=> restart_autoneg_bit) else $error("restart");
    restart_pulse_a: assert property (
        !(req.wr && req.addr == PAV_ADDR_ADV) |=> !restart_autoneg_bit)
        else $error("restart stuck");
    cover property (an.load);
    cover property (ctl.coding_bypass);
    cover property (wv ##1 !req.wr);
endmodule // pav_regs_asserts
bind pav_regs pav_regs_asserts pav_regs_asserts_inst (.*);

// [dv/pav_partner.sv]
`timescale 1ns/1ps
module pav_partner (
    input  wire logic        clock, // clk
    input  wire logic        start, // negotiate
    input  wire logic [15:0] ability, // advertised
    output pav_pkg::pav_an_t an // results
);
    import pav_pkg::*;
    logic [1:0] n = 2'h0;
    initial an = '0;
    // fields carry junk outside the load pulse
    always @(posedge clock) begin
        n <= start ? 2'h3 : n - 2'(n != 2'h0);
        an.load <= n == 2'h1;
        an.partner <= n == 2'h1 ? ability : ~ability;
        an.expansion <= n == 2'h1 ? 16'h0003 : 16'hFFFC;
    end
endmodule // pav_partner

// [dv/pav_regs_tb.sv]
`timescale 1ns/1ps
module pav_regs_tb;
    import pav_pkg::*;
    logic clock = 0, rst = 1, go = 0, rev = 0, lb = 0, ane = 1, f100 = 0;
    logic [15:0] rdata, ab = 16'h05E1;
    logic rvalid, rs;
    pav_req_t req = '0;
    pav_an_t an;
    pav_ctl_t ctl;
    int fails = 0, samples_checked = 0, cyc = 0;
    always #2 clock = ~clock;
    pav_partner pav_partner_inst (.clock(clock), .start(go), .ability(ab),
        .an(an));
    pav_regs pav_regs_inst (.clock(clock), .rst(rst), .req(req),
        .rdata(rdata), .rvalid(rvalid), .an(an), .rx_reversed(rev),
        .loopback_ctrl(lb), .an_enabled(ane), .forced_100tx(f100),
        .ctl(ctl), .restart_autoneg_bit(rs));
    task chk(string n, logic [15:0] s, logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("Error %s exp %h got %h", n, e, s);
        end
    endtask
    task end_sim;
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(logic [4:0] a, logic [15:0] d);
        @(negedge clock) req = '{1'b0, 1'b1, a, d};
        @(negedge clock) req.wr = 1'b0;
    endtask
    task rd(logic [4:0] a, logic [15:0] e);
        @(negedge clock) req = '{1'b1, 1'b0, a, 16'h0000};
        @(negedge clock) req.rd = 1'b0;
        chk("rvalid", rvalid, 16'h0001);
        chk("rdata", rdata, e);
    endtask
    task t_reset;
        rd(PAV_ADDR_ADV, 16'h0021);
        rd(PAV_ADDR_PARTNER, PAV_PARTNER_RST);
        rd(PAV_ADDR_EXPAN, PAV_EXPAN_RST);
        rd(PAV_ADDR_VENDOR, PAV_VENDOR_RST);
        chk("adv", ctl.adv_10half_ability, 16'h0001);
    endtask
    task t_adv;
        for (int i = 0; i < 5; i++) begin
            wr(PAV_ADDR_ADV, 16'(i));
            chk("restart", rs, 16'h0001);
            rd(PAV_ADDR_ADV, 16'h0001);
        end
        chk("adv", ctl.adv_10half_ability, 16'h0000);
    endtask
    task t_neg;
        wr(PAV_ADDR_PARTNER, 16'hFFFF);
        wr(PAV_ADDR_EXPAN, 16'hFFFF);
        rd(PAV_ADDR_EXPAN, PAV_EXPAN_RST);
        rd(PAV_ADDR_PARTNER, PAV_PARTNER_RST);
        @(negedge clock) go = 1;
        @(negedge clock) go = 0;
        // the read lands in the cycle right after the load pulse
        repeat (3) @(negedge clock);
        rd(PAV_ADDR_PARTNER, ab);
        rd(PAV_ADDR_EXPAN, 16'h0003);
    endtask
    task t_vnd;
        ane = 0;
        f100 = 1;
        rev = 1;
        wr(PAV_ADDR_VENDOR, 16'hFFFF);
        rd(PAV_ADDR_VENDOR, PAV_VENDOR_RST | PAV_VENDOR_WMASK);
        chk("ctl", ctl, 16'h003C);
        wr(PAV_ADDR_VENDOR, 16'h0001);
        rd(PAV_ADDR_VENDOR, 16'h0151);
        chk("ctl", ctl, 16'h000A);
        lb = 1;
        repeat (2) @(negedge clock);
        chk("ctl", ctl, 16'h0008);
        rev = 0;
        wr(PAV_ADDR_VENDOR, 16'h0010);
        rd(PAV_ADDR_VENDOR, 16'h0140);
        chk("ctl", ctl, 16'h0000);
        wr(PAV_ADDR_VENDOR, 16'h0030);
        rd(PAV_ADDR_VENDOR, 16'h0170);
        chk("ctl", ctl, 16'h0018);
        rev = 1;
        wr(PAV_ADDR_VENDOR, 16'h0020);
        rd(PAV_ADDR_VENDOR, 16'h0160);
        chk("ctl", ctl, 16'h0010);
        ane = 1;
        wr(PAV_ADDR_VENDOR, 16'h0002);
        rd(PAV_ADDR_VENDOR, 16'h0152);
        chk("ctl", ctl, 16'h0008);
    endtask
    always @(negedge clock) if (++cyc == 2000) begin
        fails++;
        end_sim;
    end
    initial begin
        repeat (3) @(negedge clock);
        rst = 0;
        t_reset;
        t_adv;
        t_neg;
        t_vnd;
        end_sim;
    end
endmodule // pav_regs_tb
